// ### logic/rx_buf_manager.sv
// Receive buffer manager: descriptor walk, buffer fill and status write-back.
// Assumes the memory port, the receive byte stream and AXI4-Lite share aclk.
// Function
// - Bit 20 flags priority tagged frames
// - Bits 19:17 carry the VLAN priority
// - Bit 16 carries the canonical format bit
// - Bit 15 marks the buffer ending a frame
// - Bit 14 marks the buffer starting a frame
// - Bits 13:12 give offset, or length in jumbo
// - Bits 11:0 give the frame length
// - Fetch descriptor as soon as a frame starts
// - Write data only for accepted frames; recover on error
// - After wrap or 1024th descriptor restart at base
// - Pointer is base plus 11-bit word counter
// - Counter clears after wrap status or rolls over
// - Set used bit of each consumed buffer
// - Receive error recovers only the current buffer
// - Used descriptor sets buffer-not-available and event
// - Used descriptor mid-frame drops it, counts error
// - Bus error or late grant flags overrun, recovers
// - FCS strip omits FCS and shortens length
// - Bit 21 flags the VLAN type identifier
// - First buffer starts at configured byte offset
// - Bits 31:22 carry broadcast and match flags
`timescale 1ns/1ps
module rx_buf_manager #(
    parameter int GRANT_CYCLES = rx_buf_pkg::LATENCY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire rx_buf_pkg::rx_beat_s rx_beat,
    input wire rx_buf_pkg::rx_info_s rx_info,
    output logic rx_ready,
    output rx_buf_pkg::mem_req_s mem_req,
    input wire rx_buf_pkg::mem_rsp_s mem_rsp,
    output logic bna_event,
    output logic overrun_event
);
    import rx_buf_pkg::*;

    typedef struct packed {
        mgr_state_e st;
        logic rx_en, jumbo, fcs_strip, bna, ovr, bna_evt, ovr_evt;
        logic [1:0] offset;
        logic [15:0] res_err;
        logic [29:0] base;
        logic [10:0] cnt;
        logic [29:0] buf_addr;
        logic wrap, sof_buf, frame_end;
        logic [7:0] bcount;
        logic [13:0] len;
        logic [31:0] word;
        logic [3:0] strb;
        rx_info_s info;
        mem_req_s mreq;
        logic [7:0] timer;
        logic rx_ready, aw_got, w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } mgr_regs_s;

    mgr_regs_s s_reg;
    mgr_regs_s s_next;
    logic [31:0] desc_addr, data_addr, stat_word;
    logic [1:0] b1312, lane;
    logic vlan, prio_tag, take, done_req, timeout, fault, keep, last_in_buf;

    function automatic mem_req_s mem_cmd(input logic wr, input logic [31:0] a,
                                         input logic [31:0] d, input logic [3:0] b);
        mem_req_s r;
        r.valid = 1'b1;
        r.write = wr;
        r.addr = a;
        r.wdata = d;
        r.wstrb = b;
        return r;
    endfunction

    // ==========================================
    // Address and status word
    assign desc_addr = {s_reg.base, 2'b00} + {19'h0_0000, s_reg.cnt, 2'b00};
    assign data_addr = {s_reg.buf_addr, 2'b00} + {25'h000_0000, s_reg.bcount[6:2], 2'b00};
    assign vlan = (s_reg.info.type_id == VLAN_TPID);
    assign prio_tag = vlan && (s_reg.info.tci[11:0] == 12'h000);
    assign b1312 = s_reg.jumbo ? s_reg.len[13:12] : s_reg.offset;
    // Only the final buffer carries full status; others just SOF and bits 13:12
    assign stat_word = s_reg.frame_end ?
        {s_reg.info.match & MATCH_MASK, vlan, prio_tag,
         s_reg.info.tci[15:13], s_reg.info.tci[12],
         1'b1, s_reg.sof_buf, b1312, s_reg.len[11:0]}
        : {16'h0000, 1'b0, s_reg.sof_buf, b1312, 12'h000};

    assign take = rx_beat.valid && s_reg.rx_ready;
    assign done_req = s_reg.mreq.valid && mem_rsp.ack;
    // A grant slower than the FIFO can cover would lose bytes, so give up
    assign timeout = s_reg.mreq.valid && !mem_rsp.ack
                     && (s_reg.timer == 8'(GRANT_CYCLES - 1));
    assign fault = (done_req && mem_rsp.err) || timeout;
    assign lane = s_reg.bcount[1:0];
    assign keep = !(s_reg.fcs_strip && rx_beat.fcs);
    assign last_in_buf = (s_reg.bcount + 8'h01) == BUF_BYTES;

    // ==========================================
    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.bna_evt = 1'b0;
        s_next.ovr_evt = 1'b0;
        s_next.timer = (s_reg.mreq.valid && !mem_rsp.ack) ? s_reg.timer + 8'h01 : 8'h00;

        if (awvalid && s_reg.awready) begin
            s_next.aw_addr = awaddr;
            s_next.aw_got = 1'b1;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
            s_next.w_got = 1'b1;
        end
        if (bready && s_reg.bvalid) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            case (s_reg.aw_addr)
                OFS_CTRL: begin
                    if (s_reg.w_strb[CTRL_RX_EN / 8]) begin
                        s_next.rx_en = s_reg.w_data[CTRL_RX_EN];
                    end
                end
                OFS_CONFIG: begin
                    if (s_reg.w_strb[CFG_JUMBO / 8]) begin
                        s_next.jumbo = s_reg.w_data[CFG_JUMBO];
                    end
                    if (s_reg.w_strb[CFG_OFS_LO / 8]) begin
                        s_next.offset = s_reg.w_data[CFG_OFS_LO +: 2];
                    end
                    if (s_reg.w_strb[CFG_FCS_STRIP / 8]) begin
                        s_next.fcs_strip = s_reg.w_data[CFG_FCS_STRIP];
                    end
                end
                OFS_STATUS: begin
                    // Write one to clear; a hardware set below still wins
                    if (s_reg.w_strb[STS_BNA / 8] && s_reg.w_data[STS_BNA]) begin
                        s_next.bna = 1'b0;
                    end
                    if (s_reg.w_strb[STS_OVR / 8] && s_reg.w_data[STS_OVR]) begin
                        s_next.ovr = 1'b0;
                    end
                end
                OFS_QPTR: begin
                    if (s_reg.w_strb == STRB_ALL) begin
                        s_next.base = s_reg.w_data[31:2];
                        s_next.cnt = 11'h000;
                    end
                end
                OFS_RES_ERR: begin
                end
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end

        if (rready && s_reg.rvalid) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            case (araddr)
                OFS_CTRL: s_next.rdata[CTRL_RX_EN] = s_reg.rx_en;
                OFS_CONFIG: begin
                    s_next.rdata[CFG_JUMBO] = s_reg.jumbo;
                    s_next.rdata[CFG_OFS_LO +: 2] = s_reg.offset;
                    s_next.rdata[CFG_FCS_STRIP] = s_reg.fcs_strip;
                end
                OFS_STATUS: begin
                    s_next.rdata[STS_BNA] = s_reg.bna;
                    s_next.rdata[STS_OVR] = s_reg.ovr;
                end
                OFS_QPTR: s_next.rdata = desc_addr;
                OFS_RES_ERR: s_next.rdata[15:0] = s_reg.res_err;
                default: s_next.rresp = RESP_SLVERR;
            endcase
        end

        if (fault) begin
            // Leave the counter alone so the next accepted frame reuses the buffer
            s_next.ovr = 1'b1;
            s_next.ovr_evt = 1'b1;
            s_next.mreq.valid = 1'b0;
            s_next.st = s_reg.frame_end ? S_IDLE : S_DROP;
        end else begin
            unique case (s_reg.st)
                S_IDLE: begin
                    if (s_reg.rx_en && rx_beat.valid && rx_beat.sof) begin
                        s_next.st = S_FETCH;
                        s_next.info = rx_info;
                        s_next.len = 14'h0000;
                        s_next.frame_end = 1'b0;
                        s_next.sof_buf = 1'b1;
                        s_next.bcount = {6'h00, s_reg.offset};
                        s_next.word = 32'h0000_0000;
                        s_next.strb = 4'h0;
                    end
                end
                S_FETCH: begin
                    if (!s_reg.mreq.valid) begin
                        s_next.mreq = mem_cmd(1'b0, desc_addr, 32'h0000_0000, 4'h0);
                    end else if (done_req) begin
                        s_next.mreq.valid = 1'b0;
                        if (mem_rsp.rdata[D_USED]) begin
                            s_next.bna = 1'b1;
                            s_next.bna_evt = 1'b1;
                            s_next.res_err = s_reg.res_err + 16'h0001;
                            s_next.st = S_DROP;
                        end else if (!s_reg.info.accept) begin
                            s_next.st = S_DROP;
                        end else begin
                            s_next.buf_addr = mem_rsp.rdata[31:2];
                            s_next.wrap = mem_rsp.rdata[D_WRAP];
                            s_next.st = S_FILL;
                        end
                    end
                end
                S_FILL: begin
                    if (take) begin
                        if (rx_beat.err) begin
                            // Only this buffer is recovered; earlier ones stay used
                            s_next.st = rx_beat.eof ? S_IDLE : S_DROP;
                        end else begin
                            s_next.frame_end = rx_beat.eof;
                            if (keep) begin
                                s_next.word[{lane, 3'b000} +: 8] = rx_beat.data;
                                s_next.strb[lane] = 1'b1;
                                s_next.bcount = s_reg.bcount + 8'h01;
                                s_next.len = s_reg.len + 14'h0001;
                            end
                            if (rx_beat.eof || (keep && (lane == 2'h3 || last_in_buf))) begin
                                if (s_next.strb != 4'h0) begin
                                    s_next.mreq = mem_cmd(1'b1, data_addr, s_next.word,
                                                          s_next.strb);
                                    s_next.st = S_WDATA;
                                end else begin
                                    s_next.mreq = mem_cmd(1'b1, desc_addr,
                                                          {s_reg.buf_addr, s_reg.wrap, 1'b1},
                                                          STRB_ALL);
                                    s_next.st = S_WUSED;
                                end
                            end
                        end
                    end
                end
                S_WDATA: begin
                    if (done_req) begin
                        s_next.mreq.valid = 1'b0;
                        s_next.word = 32'h0000_0000;
                        s_next.strb = 4'h0;
                        if (s_reg.frame_end || s_reg.bcount == BUF_BYTES) begin
                            s_next.mreq = mem_cmd(1'b1, desc_addr,
                                                  {s_reg.buf_addr, s_reg.wrap, 1'b1},
                                                  STRB_ALL);
                            s_next.st = S_WUSED;
                        end else begin
                            s_next.st = S_FILL;
                        end
                    end
                end
                S_WUSED: begin
                    if (done_req) begin
                        s_next.mreq = mem_cmd(1'b1, desc_addr + STAT_WORD_OFS, stat_word,
                                              STRB_ALL);
                        s_next.st = S_WSTAT;
                    end
                end
                S_WSTAT: begin
                    if (done_req) begin
                        s_next.mreq.valid = 1'b0;
                        // 11-bit word count wraps by itself after 1024 descriptors
                        s_next.cnt = s_reg.wrap ? 11'h000 : s_reg.cnt + DESC_STEP;
                        s_next.sof_buf = 1'b0;
                        s_next.bcount = 8'h00;
                        s_next.st = s_reg.frame_end ? S_IDLE : S_FETCH;
                    end
                end
                S_DROP: begin
                    if (take && rx_beat.eof) begin
                        s_next.st = S_IDLE;
                    end
                end
            endcase
        end

        s_next.rx_ready = (s_next.st == S_FILL) || (s_next.st == S_DROP);
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // Outputs
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bresp = s_reg.bresp;
    assign bvalid = s_reg.bvalid;
    assign arready = s_reg.arready;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign rvalid = s_reg.rvalid;
    assign rx_ready = s_reg.rx_ready;
    assign mem_req = s_reg.mreq;
    assign bna_event = s_reg.bna_evt;
    assign overrun_event = s_reg.ovr_evt;

    // ==========================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence sof_start;
        s_reg.st == S_IDLE && s_reg.rx_en && rx_beat.valid && rx_beat.sof;
    endsequence
    sequence desc_used;
        s_reg.st == S_FETCH && done_req && !mem_rsp.err && mem_rsp.rdata[D_USED];
    endsequence
    sequence stat_done;
        s_reg.st == S_WSTAT && done_req && !mem_rsp.err;
    endsequence

    a_fetch_on_sof: assert property (sof_start |=> s_reg.st == S_FETCH ##1
        (mem_req.valid && !mem_req.write && mem_req.addr == desc_addr))
        else $error("descriptor not fetched after frame start");
    a_used_sets_bna: assert property (desc_used |=> s_reg.bna && bna_event)
        else $error("used descriptor did not flag buffer not available");
    a_used_counts_err: assert property (desc_used |=>
        s_reg.res_err == $past(s_reg.res_err) + 16'h0001 && s_reg.st == S_DROP)
        else $error("used descriptor did not count a resource error");
    a_reject_no_fill: assert property (s_reg.st == S_FETCH && done_req && !mem_rsp.err
        && !mem_rsp.rdata[D_USED] && !s_reg.info.accept |=> s_reg.st == S_DROP)
        else $error("rejected frame reached the buffer");
    a_wrap_clears_cnt: assert property (stat_done and s_reg.wrap |=> s_reg.cnt == 11'h000)
        else $error("counter not cleared after wrap descriptor");
    a_next_desc_step: assert property (stat_done and !s_reg.wrap |=>
        s_reg.cnt == $past(s_reg.cnt) + DESC_STEP)
        else $error("descriptor counter did not step");
    a_used_bit_write: assert property (s_reg.st == S_WUSED && mem_req.valid |->
        mem_req.write && mem_req.wdata[D_USED] && mem_req.addr == desc_addr)
        else $error("used bit not written");
    a_mid_status_clear: assert property (s_reg.st == S_WSTAT && mem_req.valid
        && !s_reg.frame_end |-> mem_req.wdata[31:15] == 17'h0_0000
        && mem_req.wdata[11:0] == 12'h000)
        else $error("non-final status carries frame fields");
    a_vlan_status: assert property (s_reg.st == S_WSTAT && mem_req.valid
        && s_reg.frame_end |-> mem_req.wdata[21] == (s_reg.info.type_id == VLAN_TPID)
        && mem_req.wdata[14] == s_reg.sof_buf)
        else $error("VLAN or start flag wrong in status");
    a_overrun_recover: assert property (mem_req.valid && mem_rsp.ack && mem_rsp.err
        |=> s_reg.ovr && overrun_event && $stable(s_reg.cnt) && !mem_req.valid)
        else $error("bus error did not raise overrun");
    a_first_offset: assert property (sof_start |=> s_reg.bcount[1:0] == $past(s_reg.offset))
        else $error("first buffer offset not applied");
endmodule // rx_buf_manager

// ### logic/rx_buf_pkg.sv
// Constants, register map and carriers for the receive buffer manager.
// Assumes bus, memory port and receive stream share one clock at 40 MHz.
package rx_buf_pkg;
    // ==========================================
    // Register map and fields
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_QPTR = 8'h0C;
    localparam logic [7:0] OFS_RES_ERR = 8'h10;
    localparam int CTRL_RX_EN = 0;
    localparam int CFG_JUMBO = 3;
    localparam int CFG_OFS_LO = 14;
    localparam int CFG_FCS_STRIP = 17;
    localparam int STS_BNA = 0;
    localparam int STS_OVR = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] STRB_ALL = 4'hF;

    // ==========================================
    // Descriptor layout and buffer geometry
    localparam int D_USED = 0;
    localparam int D_WRAP = 1;
    localparam logic [7:0] BUF_BYTES = 8'h80;
    localparam logic [10:0] DESC_STEP = 11'h002;
    localparam logic [31:0] STAT_WORD_OFS = 32'h0000_0004;
    localparam logic [15:0] VLAN_TPID = 16'h8100;
    // Match flags map onto status bits 31..22; the bit for 27 is reserved
    localparam logic [9:0] MATCH_MASK = 10'h3DF;

    // ==========================================
    // Timing
    localparam int CLK_NS = 25;
    localparam int LATENCY_NS = 860;
    // Longest wait, so it rounds down
    localparam int LATENCY_CYC = LATENCY_NS / CLK_NS;

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_FILL, S_WDATA, S_WUSED, S_WSTAT, S_DROP
    } mgr_state_e;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic err;
        logic fcs;
        logic [7:0] data;
    } rx_beat_s;

    typedef struct packed {
        logic accept;
        logic [9:0] match;
        logic [15:0] type_id;
        logic [15:0] tci;
    } rx_info_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } mem_req_s;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } mem_rsp_s;
endpackage

// ### sim/mem_model.sv
// Memory partner: byte store answering one word request at a time.
// Assumes requests move on aclk and stay stable until ack.
`timescale 1ns/1ps
module mem_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire rx_buf_pkg::mem_req_s mem_req,
    input wire logic [7:0] delay,
    input wire logic fail,
    output rx_buf_pkg::mem_rsp_s mem_rsp
);
    import rx_buf_pkg::*;
    logic [7:0] mem [logic [31:0]];
    int cnt = 0;
    // Unwritten bytes read as an address pattern, so no lucky zero
    always @(posedge aclk) begin
        mem_rsp <= '0;
        cnt <= (!mem_req.valid || mem_rsp.ack) ? 0 : cnt + 1;
        if (aresetn && mem_req.valid && !mem_rsp.ack && cnt >= delay) begin
            mem_rsp.ack <= 1'b1;
            mem_rsp.err <= fail;
            for (int i = 0; i < 4; i++) begin
                if (mem_req.write && mem_req.wstrb[i] && !fail)
                    mem[mem_req.addr + i] = mem_req.wdata[8*i+:8];
                mem_rsp.rdata[8*i+:8] <= mem.exists(mem_req.addr + i) ?
                    mem[mem_req.addr + i] : ~mem_req.addr[7:0];
            end
        end
    end
endmodule // mem_model

// ### sim/tb_top.sv
// Bench: random frames, error, overrun and used-buffer cases.
// Assumes the package, the manager and mem_model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import rx_buf_pkg::*;
    localparam logic [31:0] BASE = 32'h0000_1000;
    localparam logic [31:0] BUFA = 32'h0000_2000;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, fail = 0;
    logic awready, wready, bvalid, arready, rvalid, rx_ready, bna_event, overrun_event;
    logic [7:0] awaddr = 0, araddr = 0, delay = 0;
    logic [7:0] b [200];
    logic [31:0] wdata = 0, rdata, cfg, d;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, r;
    rx_beat_s rx_beat = '0;
    rx_info_s rx_info = '0;
    mem_req_s mem_req;
    mem_rsp_s mem_rsp;
    int n_errors = 0, comparisons = 0, n_bna = 0, n_ovr = 0, cur = 0, res = 0;
    int plan [5] = '{3, 5, 0, 1, 4};
    always #12.5 aclk = ~aclk;
    rx_buf_manager #(.GRANT_CYCLES(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_beat(rx_beat),
        .rx_info(rx_info), .rx_ready(rx_ready), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .bna_event(bna_event), .overrun_event(overrun_event));
    mem_model u_mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req), .delay(delay),
        .fail(fail), .mem_rsp(mem_rsp));
    always @(posedge aclk) begin
        n_bna += bna_event === 1'b1;
        n_ovr += overrun_event === 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, v, STRB_ALL};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        rready <= 0;
    endtask
    function automatic logic [7:0] rdb(input logic [31:0] a);
        return u_mem.mem.exists(a) ? u_mem.mem[a] : 8'hxx;
    endfunction
    function automatic logic [31:0] rd32(input logic [31:0] a);
        return {rdb(a + 3), rdb(a + 2), rdb(a + 1), rdb(a)};
    endfunction
    function automatic logic [31:0] init0(input int j, input int m);
        return 32'(BUFA + 128 * (j % 4) + 2 * (j % 4 == 3) + (m == 4 && j % 4 == cur));
    endfunction
    function automatic logic [31:0] stat(input bit s, input bit e, input logic [13:0] len);
        logic [31:0] v;
        v = '0;
        v[15:14] = {e, s};
        v[13:12] = cfg[CFG_JUMBO] ? len[13:12] : cfg[15:14];
        if (!e) return v;
        v[11:0] = len[11:0];
        v[31:22] = rx_info.match & MATCH_MASK;
        v[21] = rx_info.type_id === VLAN_TPID;
        v[20] = v[21] && rx_info.tci[11:0] === 12'h000;
        v[19:16] = rx_info.tci[15:12];
        return v;
    endfunction
    // Modes: 0 good, 1 error beat, 2 filter reject, 3 bus error, 4 used, 5 late grant
    task automatic frame(input int mode);
        int n, st, e, nu, ov, bn, k;
        logic [31:0] a;
        {ov, bn} = {n_ovr, n_bna};
        cfg = $urandom & 32'h0002_C008;
        axi_wr(OFS_CONFIG, cfg);
        n = 5 + $urandom % 196;
        st = cfg[CFG_FCS_STRIP] ? n - 4 : n;
        e = $urandom % st;
        k = $urandom % 2;
        rx_info <= '{mode != 2, 10'($urandom), k ? VLAN_TPID : 16'h0800,
            k ? 16'($urandom) & ($urandom % 2 ? 16'hFFFF : 16'hF000) : 16'h0000};
        fail <= mode == 3;
        delay <= mode == 5 ? 8'h0C : 8'($urandom % 3);
        u_mem.mem.delete();
        for (int i = 0; i < 16; i++) u_mem.mem[BASE + 8 * (i / 4) + i % 4] =
            8'(init0(i / 4, mode) >> 8 * (i % 4));
        for (int i = 0; i < n; i++) begin
            b[i] = 8'($urandom);
            rx_beat <= '{1'b1, i == 0, i == n - 1, mode == 1 && i == e, i >= n - 4, b[i]};
            k = 0;
            do @(posedge aclk); while (rx_ready !== 1'b1 && ++k < 3000);
        end
        rx_beat <= '0;
        k = 0;
        for (int t = 0; t < 4000 && k < 20; t++) begin
            @(posedge aclk);
            k = mem_req.valid ? 0 : k + 1;
        end
        nu = mode == 0 ? (cfg[15:14] + st - 1) / 128 + 1 : mode == 1 ? (cfg[15:14] + e) / 128 : 0;
        for (int j = 0; j < nu; j++) begin
            a = BASE + 8 * ((cur + j) % 4);
            chk(rd32(a), init0(cur + j, 0) | 1);
            chk(rd32(a + 4), stat(j == 0, mode == 0 && j == nu - 1, 14'(st)));
        end
        chk(rd32(BASE + 8 * ((cur + nu) % 4)), init0(cur + nu, mode));
        for (int i = 0; i < st && mode == 0; i++) begin
            a = cfg[15:14] + i;
            chk(rdb(BUFA + 128 * ((cur + a / 128) % 4) + a % 128), b[i]);
        end
        cur = (cur + nu) % 4;
        axi_rd(OFS_QPTR);
        if (mode != 4) chk(d, BASE + 8 * cur);
        axi_rd(OFS_STATUS);
        chk(d[1:0], {mode == 3 || mode == 5, mode == 4});
        chk(n_ovr - ov, mode == 3 || mode == 5);
        chk(n_bna - bn, mode == 4);
        res += mode == 4;
        axi_rd(OFS_RES_ERR);
        chk(d[15:0], res[15:0]);
        axi_wr(OFS_STATUS, 32'h0000_0003);
        $display("frame mode %0d length %0d done", mode, n);
    endtask
    initial begin
        void'($urandom(11428));
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        axi_rd(8'h40);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0000_0000);
        axi_wr(8'h40, 32'h0000_0001);
        chk(r, RESP_SLVERR);
        axi_wr(OFS_QPTR, BASE);
        chk(r, RESP_OKAY);
        axi_wr(OFS_CTRL, 32'h0000_0001);
        for (int k = 0; k < 25; k++) frame($urandom % 4 == 0 ? 1 + $urandom % 2 : 0);
        foreach (plan[i]) frame(plan[i]);
        close_out();
    end
    initial begin
        #2_000_000;
        n_errors++;
        close_out();
    end
endmodule // tb_top
